// >>> design/csu_pkg.sv
// Package with constants, types and carriers for the clock select and start-up unit.
package csu_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map on the Wishbone slave (byte addresses, one word each).
    localparam logic [7:0] CSU_ADR_CTRL = 8'h00;
    localparam logic [7:0] CSU_ADR_STATUS = 8'h04;
    localparam logic [7:0] CSU_ADR_FUSE = 8'h08;
    localparam int CSU_ADR_W = 8;

    // Field positions.
    localparam int CSU_CTRL_SLEEP_LSB = 0;
    localparam int CSU_STAT_STATE_LSB = 0;
    localparam int CSU_STAT_SRC_LSB = 4;
    localparam int CSU_STAT_IRST_BIT = 8;
    localparam int CSU_STAT_OSC_BIT = 9;
    localparam int CSU_STAT_DIV_BIT = 10;
    localparam int CSU_FUSE_SEL_LSB = 0;
    localparam int CSU_FUSE_SUT_LSB = 4;
    localparam int CSU_FUSE_DIV_BIT = 6;

    // Shipped fuse values: calibrated RC, longest start-up, divide-by-eight programmed.
    localparam logic [3:0] CSU_RST_SEL = 4'h2;
    localparam logic [1:0] CSU_RST_SUT = 2'h2;
    localparam logic CSU_RST_DIV8 = 1'b0;

    // Cycle counts that stay within 4096; the longer ones are top-level parameters.
    localparam logic [15:0] CSU_TOUT_NONE = 16'h0000;
    localparam logic [15:0] CSU_TOUT_SHORT = 16'h1000;
    localparam logic [15:0] CSU_SU_EXT = 16'h0006;
    localparam logic [15:0] CSU_SU_FAST = 16'h0102;
    localparam logic [15:0] CSU_SU_1K = 16'h0400;
    localparam logic [2:0] CSU_DIV8_LAST = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep modes written into the control register.
    localparam logic [2:0] CSU_SLP_ACTIVE = 3'h0;
    localparam logic [2:0] CSU_SLP_IDLE = 3'h1;
    localparam logic [2:0] CSU_SLP_ADC = 3'h2;
    localparam logic [2:0] CSU_SLP_SAVE = 3'h3;
    localparam logic [2:0] CSU_SLP_DOWN = 3'h4;

    // Decoded clock source.
    typedef enum logic [2:0] {
        CSU_SRC_EXT, CSU_SRC_RSVD, CSU_SRC_RC_CAL, CSU_SRC_RC128,
        CSU_SRC_LF_XTAL, CSU_SRC_FS_XTAL, CSU_SRC_LP_XTAL
    } csu_src_t;

    // Start-up sequencer states.
    typedef enum {
        CSU_ST_HOLD, CSU_ST_TIMEOUT, CSU_ST_STARTUP, CSU_ST_RUN, CSU_ST_OSC_OFF, CSU_ST_WAKE
    } csu_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Non-volatile configuration bits; a zero means programmed.
    typedef struct packed {
        logic [3:0] clock_source_select;
        logic [1:0] startup_time_select;
        logic divide_by_eight_fuse;
    } csu_fuse_t;

    // Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [CSU_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } csu_wb_req_t;

    // Gated clock enables, one per switchable domain.
    typedef struct packed {
        logic core;
        logic mem;
        logic io;
        logic adc;
    } csu_dom_t;

endpackage

// >>> design/csu_tick_counter.sv
// Tick counter used for both the watchdog time-out and the oscillator ripple count.
`timescale 1ns/1ps
module csu_tick_counter
    import csu_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] target,
    output logic done
);

    // All state of the counter in one record.
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } csu_cnt_st_t;

    csu_cnt_st_t q_ff;
    csu_cnt_st_t nxt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Count ticks while running; a zero target finishes in one cycle.
    always_comb begin
        nxt_q = q_ff;
        if (clear) begin
            nxt_q = '0;
        end else if (run && !q_ff.done) begin
            if (q_ff.cnt >= target) begin
                nxt_q.done = 1'b1;
            end else if (tick) begin
                nxt_q.cnt = q_ff.cnt + W'(1);
            end
        end
    end

    // Register the whole record.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign done = q_ff.done;

endmodule

// >>> design/csu_clock_gate.sv
// Glitch-free clock gate for one switchable clock domain.
`timescale 1ns/1ps
module csu_clock_gate (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    output logic gclk
);

    // The enable is re-timed on the falling edge, so it only changes while clk is low.
    typedef struct packed {
        logic en;
    } csu_gate_st_t;

    csu_gate_st_t q_ff;
    csu_gate_st_t nxt_q;

    // Next enable value.
    always_comb begin
        nxt_q.en = enable;
    end

    // Low-phase latch equivalent; no high phase is ever shortened.
    always_ff @(negedge clk) begin
        if (!reset_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign gclk = clk & q_ff.en;

endmodule

// >>> design/csu_clock_startup.sv
// Top of the clock select and start-up unit with its Wishbone register slave.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module csu_clock_startup
    import csu_pkg::*;
#(
    parameter int TOUT_LONG = 8192,
    parameter int SU_XTAL = 16384,
    parameter int SU_LF_XTAL = 32768
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire csu_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire csu_fuse_t fuse_in,
    input wire logic reset_request,
    input wire logic brownout_detector,
    input wire logic watchdog_tick,
    input wire logic osc_tick,
    input wire logic wake_event,
    input wire logic async_timer_clock_in,
    output logic async_timer_clock,
    output logic osc_enable,
    output logic internal_reset_n,
    output csu_src_t source_decoded,
    output logic timeout_unguarded,
    output logic core_clock,
    output logic mem_clock,
    output logic io_clock,
    output logic adc_clock
);

    ////////////////////////////////////////////////////////////////////////////////
    // Refuse counts that do not fit the 16-bit counters.
    if (TOUT_LONG < 1 || TOUT_LONG > 65535 || SU_XTAL < 1 || SU_XTAL > 65535
        || SU_LF_XTAL < 1 || SU_LF_XTAL > 65535) begin : g_chk
        $error("csu_clock_startup: count parameter out of range");
    end

    // All state of the top in one record.
    typedef struct packed {
        csu_state_t state;
        csu_fuse_t fuse;
        logic [2:0] sleep;
        logic [2:0] div_cnt;
        logic ack;
        logic [31:0] rdata;
    } csu_top_st_t;

    csu_top_st_t q_ff;
    csu_top_st_t nxt_q;

    logic tout_done; // Watchdog time-out reached.
    logic su_done; // Oscillator ripple count reached.
    logic [15:0] tout_target; // Chosen time-out in watchdog cycles.
    logic [15:0] su_target; // Chosen start-up in oscillator cycles.
    logic div_tick; // One cycle of the divided system clock.
    logic wb_hit; // A new bus request in this cycle.
    logic [31:0] rd_mux; // Read data before registering.
    csu_dom_t dom_en; // Domain enables before the gates.

    ////////////////////////////////////////////////////////////////////////////////
    // Four-bit source decode; ranges follow the select table.
    function automatic csu_src_t csu_decode(input logic [3:0] sel);
        csu_src_t s;
        s = CSU_SRC_EXT;
        if (sel[3]) begin
            s = CSU_SRC_LP_XTAL;
        end else if (sel[2:1] == 2'h3) begin
            s = CSU_SRC_FS_XTAL;
        end else if (sel[2:1] == 2'h2) begin
            s = CSU_SRC_LF_XTAL;
        end else if (sel == 4'h3) begin
            s = CSU_SRC_RC128;
        end else if (sel == 4'h2) begin
            s = CSU_SRC_RC_CAL;
        end else if (sel == 4'h1) begin
            s = CSU_SRC_RSVD;
        end
        return s;
    endfunction

    assign source_decoded = csu_decode(q_ff.fuse.clock_source_select);

    ////////////////////////////////////////////////////////////////////////////////
    // Time-out choice from the start-up bits, and for CSU_SRC_LP_XTAL and CSU_SRC_FS_XTAL also the lowest select bit.
    always_comb begin
        tout_target = CSU_TOUT_NONE;
        if (source_decoded == CSU_SRC_LP_XTAL || source_decoded == CSU_SRC_FS_XTAL) begin
            case ({q_ff.fuse.clock_source_select[0], q_ff.fuse.startup_time_select})
                3'h0: tout_target = CSU_TOUT_SHORT;
                3'h1: tout_target = 16'(TOUT_LONG);
                3'h2: tout_target = CSU_TOUT_NONE;
                3'h3: tout_target = CSU_TOUT_SHORT;
                3'h4: tout_target = 16'(TOUT_LONG);
                3'h5: tout_target = CSU_TOUT_NONE;
                3'h6: tout_target = CSU_TOUT_SHORT;
                default: tout_target = 16'(TOUT_LONG);
            endcase
        end else begin
            // Other sources pick the time-out from the start-up bits alone.
            case (q_ff.fuse.startup_time_select)
                2'h0: tout_target = CSU_TOUT_NONE;
                2'h1: tout_target = CSU_TOUT_SHORT;
                default: tout_target = 16'(TOUT_LONG);
            endcase
        end
    end

    // A disabled time-out without a brown-out detector is flagged, never silently taken.
    assign timeout_unguarded = (tout_target == CSU_TOUT_NONE) && !brownout_detector;

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator start-up count by clock type.
    always_comb begin
        su_target = CSU_SU_EXT;
        case (source_decoded)
            CSU_SRC_LF_XTAL: su_target = 16'(SU_LF_XTAL);
            CSU_SRC_LP_XTAL, CSU_SRC_FS_XTAL: begin
                case ({q_ff.fuse.clock_source_select[0], q_ff.fuse.startup_time_select})
                    3'h0, 3'h1: su_target = CSU_SU_FAST;
                    3'h2, 3'h3, 3'h4: su_target = CSU_SU_1K;
                    default: su_target = 16'(SU_XTAL);
                endcase
            end
            default: su_target = CSU_SU_EXT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time-out counter runs on watchdog ticks only after reset sources let go.
    csu_tick_counter #(.W(16)) u_tout (
        .clk(clk),
        .reset_n(reset_n),
        .clear(reset_request || q_ff.state == CSU_ST_HOLD),
        .run(q_ff.state == CSU_ST_TIMEOUT),
        .tick(watchdog_tick),
        .target(tout_target),
        .done(tout_done)
    );

    // Ripple counter on oscillator ticks, used after reset and after a wake.
    csu_tick_counter #(.W(16)) u_ripple (
        .clk(clk),
        .reset_n(reset_n),
        .clear(reset_request || !(q_ff.state == CSU_ST_STARTUP
            || q_ff.state == CSU_ST_WAKE)),
        .run(1'b1),
        .tick(osc_tick),
        .target(su_target),
        .done(su_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode: one new request is taken per transfer, answered one cycle later.
    assign wb_hit = wb_req.cyc && wb_req.stb && !q_ff.ack;

    // Read data of the addressed register; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_req.adr)
            CSU_ADR_CTRL: rd_mux[CSU_CTRL_SLEEP_LSB +: 3] = q_ff.sleep;
            CSU_ADR_STATUS: begin
                rd_mux[CSU_STAT_STATE_LSB +: 4] = 4'(q_ff.state);
                rd_mux[CSU_STAT_SRC_LSB +: 3] = source_decoded;
                rd_mux[CSU_STAT_IRST_BIT] = !internal_reset_n;
                rd_mux[CSU_STAT_OSC_BIT] = osc_enable;
                rd_mux[CSU_STAT_DIV_BIT] = !q_ff.fuse.divide_by_eight_fuse;
            end
            CSU_ADR_FUSE: begin
                rd_mux[CSU_FUSE_SEL_LSB +: 4] = q_ff.fuse.clock_source_select;
                rd_mux[CSU_FUSE_SUT_LSB +: 2] = q_ff.fuse.startup_time_select;
                rd_mux[CSU_FUSE_DIV_BIT] = q_ff.fuse.divide_by_eight_fuse;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Divide-by-eight when the fuse is programmed, else every cycle.
    assign div_tick = q_ff.fuse.divide_by_eight_fuse || (q_ff.div_cnt == CSU_DIV8_LAST);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer, register writes and bus answer.
    always_comb begin
        nxt_q = q_ff;
        nxt_q.ack = wb_hit;
        nxt_q.div_cnt = q_ff.div_cnt + 3'h1;
        if (wb_hit && !wb_req.we) begin
            nxt_q.rdata = rd_mux;
        end
        case (q_ff.state)
            CSU_ST_HOLD: begin
                // Fuses are sampled while held in reset.
                nxt_q.fuse = fuse_in;
                nxt_q.sleep = CSU_SLP_ACTIVE;
                if (!reset_request) begin
                    nxt_q.state = CSU_ST_TIMEOUT;
                end
            end
            CSU_ST_TIMEOUT: begin
                if (tout_done) begin
                    nxt_q.state = CSU_ST_STARTUP;
                end
            end
            CSU_ST_STARTUP: begin
                if (su_done) begin
                    nxt_q.state = CSU_ST_RUN;
                end
            end
            CSU_ST_RUN: begin
                if (wb_hit && wb_req.we && wb_req.sel[0] && wb_req.adr == CSU_ADR_CTRL) begin
                    nxt_q.sleep = wb_req.dat[CSU_CTRL_SLEEP_LSB +: 3];
                    if (wb_req.dat[CSU_CTRL_SLEEP_LSB +: 3] == CSU_SLP_SAVE
                        || wb_req.dat[CSU_CTRL_SLEEP_LSB +: 3] == CSU_SLP_DOWN) begin
                        nxt_q.state = CSU_ST_OSC_OFF;
                    end
                end else if (wake_event && q_ff.sleep != CSU_SLP_ACTIVE) begin
                    // Wake sources are seen on clk even with the peripheral clock gated.
                    nxt_q.sleep = CSU_SLP_ACTIVE;
                end
            end
            CSU_ST_OSC_OFF: begin
                if (wake_event) begin
                    nxt_q.state = CSU_ST_WAKE;
                end
            end
            CSU_ST_WAKE: begin
                // Only the oscillator count is applied on a wake.
                if (su_done) begin
                    nxt_q.state = CSU_ST_RUN;
                    nxt_q.sleep = CSU_SLP_ACTIVE;
                end
            end
            default: nxt_q.state = CSU_ST_HOLD;
        endcase
        if (reset_request) begin
            nxt_q.state = CSU_ST_HOLD;
        end
    end

    // Register the whole record; fuses come up at their shipped values.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_ff <= '0;
            q_ff.state <= CSU_ST_HOLD;
            q_ff.fuse <= '{CSU_RST_SEL, CSU_RST_SUT, CSU_RST_DIV8};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign wb_ack_o = q_ff.ack;
    assign wb_dat_o = q_ff.rdata;
    assign internal_reset_n = (q_ff.state == CSU_ST_RUN) || (q_ff.state == CSU_ST_OSC_OFF)
        || (q_ff.state == CSU_ST_WAKE);
    assign osc_enable = (q_ff.state != CSU_ST_OSC_OFF);

    ////////////////////////////////////////////////////////////////////////////////
    // Domain enables: nothing runs until the sequencer reaches the run state.
    always_comb begin
        dom_en = '0;
        if (q_ff.state == CSU_ST_RUN && div_tick) begin
            dom_en.core = (q_ff.sleep == CSU_SLP_ACTIVE);
            dom_en.mem = (q_ff.sleep == CSU_SLP_ACTIVE);
            dom_en.io = (q_ff.sleep <= CSU_SLP_IDLE);
            dom_en.adc = (q_ff.sleep <= CSU_SLP_ADC);
        end
    end

    // One glitch-free gate per switchable domain.
    logic [3:0] gclk_v;
    for (genvar i = 0; i < 4; i++) begin : g_gate
        csu_clock_gate u_gate (
            .clk(clk),
            .reset_n(reset_n),
            .enable(dom_en[i]),
            .gclk(gclk_v[i])
        );
    end
    assign core_clock = gclk_v[3];
    assign mem_clock = gclk_v[2];
    assign io_clock = gclk_v[1];
    assign adc_clock = gclk_v[0];

    // The asynchronous timer clock bypasses every gate and sleep mode.
    assign async_timer_clock = async_timer_clock_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer, the gating and the bus answer.
    property p_hold_on_request;
        @(posedge clk) disable iff (!reset_n)
        reset_request |=> (q_ff.state == CSU_ST_HOLD) && !internal_reset_n;
    endproperty
    a_hold_on_request: assert property (p_hold_on_request) else $error("no hold on reset");

    property p_timeout_after_release;
        @(posedge clk) disable iff (!reset_n)
        (q_ff.state == CSU_ST_HOLD) && !reset_request |=> q_ff.state == CSU_ST_TIMEOUT;
    endproperty
    a_timeout_after_release: assert property (p_timeout_after_release) else $error("no timeout");

    property p_run_needs_ripple;
        @(posedge clk) disable iff (!reset_n)
        $rose(internal_reset_n) |-> $past(q_ff.state) == CSU_ST_STARTUP && $past(su_done);
    endproperty
    a_run_needs_ripple: assert property (p_run_needs_ripple) else $error("early release");

    property p_wake_skips_timeout;
        @(posedge clk) disable iff (!reset_n)
        (q_ff.state == CSU_ST_OSC_OFF) && wake_event && !reset_request
            |=> (q_ff.state == CSU_ST_WAKE) && internal_reset_n;
    endproperty
    a_wake_skips_timeout: assert property (p_wake_skips_timeout) else $error("bad wake");

    property p_core_stopped_in_sleep;
        @(posedge clk) disable iff (!reset_n)
        (q_ff.sleep != CSU_SLP_ACTIVE) |-> !dom_en.core && !dom_en.mem;
    endproperty
    a_core_stopped_in_sleep: assert property (p_core_stopped_in_sleep) else $error("core on");

    property p_mem_follows_core;
        @(posedge clk) disable iff (!reset_n)
        dom_en.mem == dom_en.core;
    endproperty
    a_mem_follows_core: assert property (p_mem_follows_core) else $error("mem split");

    property p_adc_in_noise_mode;
        @(posedge clk) disable iff (!reset_n)
        (q_ff.state == CSU_ST_RUN) && (q_ff.sleep == CSU_SLP_ADC) && div_tick
            |-> dom_en.adc && !dom_en.io;
    endproperty
    a_adc_in_noise_mode: assert property (p_adc_in_noise_mode) else $error("adc gate");

    property p_div8_spacing;
        @(posedge clk) disable iff (!reset_n)
        dom_en.core && !q_ff.fuse.divide_by_eight_fuse |=> !dom_en.core [*7];
    endproperty
    a_div8_spacing: assert property (p_div8_spacing) else $error("divide wrong");

    property p_lf_xtal_count;
        @(posedge clk) disable iff (!reset_n)
        source_decoded == CSU_SRC_LF_XTAL |-> su_target == 16'(SU_LF_XTAL);
    endproperty
    a_lf_xtal_count: assert property (p_lf_xtal_count) else $error("lf count");

    property p_ack_one_cycle;
        @(posedge clk) disable iff (!reset_n)
        wb_hit |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack shape");

    c_reset_release: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(internal_reset_n));
    c_power_down_wake: cover property (@(posedge clk) disable iff (!reset_n)
        q_ff.state == CSU_ST_WAKE ##1 q_ff.state == CSU_ST_RUN);
    c_idle_wake: cover property (@(posedge clk) disable iff (!reset_n)
        q_ff.sleep == CSU_SLP_IDLE ##1 q_ff.sleep == CSU_SLP_ACTIVE);

endmodule

// >>> tb/csu_osc_model.sv
// Behavioural crystal, watchdog oscillator and timer crystal outside the unit.
`timescale 1ns/1ps
module csu_osc_model (
    input wire logic clk,
    input wire logic osc_enable,
    output logic osc_tick,
    output logic watchdog_tick,
    output logic async_clock
);
    logic [1:0] div_ff = 2'h0; // Divider that paces the slow sources.
    logic osc_ff = 1'b0; // Crystal output pulse.
    logic wd_ff = 1'b0; // Watchdog oscillator pulse.
    logic asy_ff = 1'b0; // Timer crystal level.
    // The crystal stops dead while disabled, so a wake really has to restart it.
    always @(posedge clk) begin
        div_ff <= div_ff + 2'h1;
        osc_ff <= osc_enable;
        wd_ff <= div_ff[0];
        asy_ff <= div_ff[1];
    end
    assign osc_tick = osc_ff;
    assign watchdog_tick = wd_ff;
    assign async_clock = asy_ff;
endmodule

// >>> tb/csu_clock_startup_tb.sv
// Self-checking bench for the clock select and start-up unit.
`timescale 1ns/1ps
module csu_clock_startup_tb;
    import csu_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, rst_req = 1'b1, bdet = 1'b0, wake = 1'b0;
    csu_wb_req_t req = '0;
    csu_fuse_t fz = 7'h14; // Shipped select 0010, start-up 10, divider programmed.
    logic [31:0] wb_dat_o, lfsr = 32'hD7191224;
    logic wb_ack_o, osc_tick, wd_tick, asy_in, asy, osc_en, irst_n, unguarded;
    logic core_clock, mem_clock, io_clock, adc_clock;
    csu_src_t src;
    logic [32:0] exp_q[$], e_m; // Expected read data, bit 32 marks a read.
    int fails = 0, comparisons = 0, cyc = 0, cnt[4], s[4];
    csu_clock_startup #(.TOUT_LONG(20), .SU_XTAL(16), .SU_LF_XTAL(24)) i_csu_clock_startup (
        .clk(clk), .reset_n(reset_n), .wb_req(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fuse_in(fz), .reset_request(rst_req), .brownout_detector(bdet),
        .watchdog_tick(wd_tick), .osc_tick(osc_tick), .wake_event(wake),
        .async_timer_clock_in(asy_in), .async_timer_clock(asy), .osc_enable(osc_en),
        .internal_reset_n(irst_n), .source_decoded(src), .timeout_unguarded(unguarded),
        .core_clock(core_clock), .mem_clock(mem_clock), .io_clock(io_clock),
        .adc_clock(adc_clock));
    csu_osc_model i_csu_osc_model (.clk(clk), .osc_enable(osc_en), .osc_tick(osc_tick),
        .watchdog_tick(wd_tick), .async_clock(asy_in));
    initial forever #5 clk = ~clk;
    always @(posedge core_clock) cnt[0]++;
    always @(posedge mem_clock) cnt[1]++;
    always @(posedge io_clock) cnt[2]++;
    always @(posedge adc_clock) cnt[3]++;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One classic cycle; for a read, d is the expected data left for the monitor.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back(we ? 33'h0 : {1'b1, d});
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: we ? d : 32'h0};
        // Only the bench timeout ends a wait for the answer.
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0)
            fails++;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watches acks, takes the oldest note and cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (wb_ack_o === 1'b1 && exp_q.size() != 0) begin
            e_m = exp_q.pop_front();
            if (e_m[32])
                chk(wb_dat_o, e_m[31:0]);
        end
        if (cyc == 3000) begin
            fails++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_n(12);
        reset_n <= 1'b1;
        wait_n(2);
        wb(1'b0, CSU_ADR_FUSE, 32'h22);
        chk(32'(src), 32'(CSU_SRC_RC_CAL));
        for (int i = 0; i < 16; i++) begin
            fz.clock_source_select <= 4'(i);
            wait_n(2);
            chk(32'(src), i > 7 ? 32'h6 : i > 5 ? 32'h5 : i > 3 ? 32'h4 : 32'(i));
        end
        fz <= 7'h11;
        wait_n(2);
        chk({31'h0, unguarded}, 32'h1);
        bdet <= 1'b1;
        wait_n(1);
        chk({31'h0, unguarded}, 32'h0);
        // A reset source returns a quarter of the way through the time-out; the count must restart.
        fz <= 7'h15;
        rst_req <= 1'b0;
        wait_n(10);
        rst_req <= 1'b1;
        wait_n(2);
        rst_req <= 1'b0;
        // Without the restart the release would come twelve cycles earlier.
        wait_n(46);
        chk({31'h0, irst_n}, 32'h0);
        for (int k = 0; k < 40 && irst_n !== 1'b1; k++)
            @(posedge clk);
        chk({31'h0, irst_n}, 32'h1);
        wb(1'b0, CSU_ADR_STATUS, 32'h223);
        // Active, idle and converter sleep, with random filler in the upper bits.
        for (int m = 0; m < 3; m++) begin
            lfsr = lfsr_next(lfsr);
            wb(1'b1, CSU_ADR_CTRL, {lfsr[31:3], 3'(m)});
            @(negedge clk) s = cnt;
            wait_n(16);
            @(negedge clk);
            chk(32'(cnt[0] != s[0]), 32'(m == 0));
            chk(32'(cnt[1] - s[1]), 32'(cnt[0] - s[0]));
            chk(32'(cnt[2] != s[2]), 32'(m < 2));
            chk(32'(cnt[3] != s[3]), 32'h1);
            @(posedge clk);
            wake <= 1'b1;
            wait_n(1);
            wake <= 1'b0;
            wait_n(2);
        end
        wb(1'b1, CSU_ADR_CTRL, 32'h4);
        wait_n(3);
        chk({31'h0, osc_en}, 32'h0);
        chk({31'h0, asy}, {31'h0, asy_in});
        wake <= 1'b1;
        wait_n(1);
        wake <= 1'b0;
        wait_n(14);
        wb(1'b0, CSU_ADR_STATUS, 32'h223);
        wb(1'b0, 8'h0C, 32'h0);
        // Low-power crystal, select 1001, start-up 01, divider programmed: no time-out.
        rst_req <= 1'b1;
        fz <= 7'h4A;
        wait_n(2);
        rst_req <= 1'b0;
        wait_n(14);
        chk({31'h0, irst_n}, 32'h0);
        for (int k = 0; k < 40 && irst_n !== 1'b1; k++)
            @(posedge clk);
        chk({31'h0, irst_n}, 32'h1);
        wb(1'b0, CSU_ADR_STATUS, 32'h663);
        @(negedge clk) s = cnt;
        wait_n(16);
        @(negedge clk);
        chk(cnt[0] - s[0], 32'h2);
        @(posedge clk);
        wb(1'b1, CSU_ADR_CTRL, 32'h3);
        wait_n(3);
        chk({31'h0, osc_en}, 32'h0);
        complete_run();
    end
endmodule
